// File: verilog/pfs_top.sv
`timescale 1ns/100ps
module pfs_top import pfs_pkg::*; #(
  parameter int SS_CYC = SS_CYCLES
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // Register port
  input wire logic [3:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [15:0] reg_rdata_out,
  // Management link
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  output logic smbalert_out,
  output logic smbalert_oe_out,
  // Address select codes, from the on-chip converter
  input wire logic [7:0] addr_select_low_in,
  input wire logic [7:0] addr_select_high_in,
  // Fault sensing
  input wire logic input_undervoltage_in,
  input wire logic output_undervoltage_in,
  input wire logic output_overvoltage_in,
  input wire logic power_good_window_in,
  input wire logic high_side_overcurrent_in,
  input wire logic low_side_overcurrent_in,
  input wire logic external_overtemp_in,
  input wire logic thermal_shutdown_in,
  input wire logic temp_reset_ok_in,
  input wire logic cycle_end_in,
  input wire logic soft_start_done_in,
  // Power stage
  output logic high_side_enable_out,
  output logic low_side_enable_out,
  output logic low_gate_drive_force_out,
  output logic soft_start_req_out,
  // Non-volatile configuration
  input wire logic [CFG_W-1:0] nvm_default_in,
  output logic [CFG_W-1:0] nvm_image_out,
  output logic nvm_store_out
);
  typedef enum logic [2:0] {B_IDLE, B_RX, B_RXACK, B_ACKHOLD, B_TX, B_TXACK} pfs_bus_e;

  pfs_fault_if flt();
  logic [6:0] my_addr;
  logic addr_fb;

  pfs_addr_sel u_addr (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .addr_select_low_in(addr_select_low_in),
    .addr_select_high_in(addr_select_high_in),
    .addr_out(my_addr),
    .fallback_out(addr_fb)
  );

  pfs_fault_ctrl #(
    .HIC_CYC(SS_CYC * HICCUP_SS_PERIODS)
  ) u_fault (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .flt(flt),
    .sense_in({cycle_end_in, soft_start_done_in, temp_reset_ok_in, thermal_shutdown_in,
      external_overtemp_in, power_good_window_in, low_side_overcurrent_in,
      high_side_overcurrent_in, output_overvoltage_in, output_undervoltage_in,
      input_undervoltage_in}),
    .high_side_enable_out(high_side_enable_out),
    .low_side_enable_out(low_side_enable_out),
    .low_gate_drive_force_out(low_gate_drive_force_out),
    .soft_start_req_out(soft_start_req_out)
  );

  // either bus rate
  // Link synchronisers; 200 MHz gives ample samples per bit at either rate
  logic scl_s1_ff, scl_s2_ff, scl_s3_ff;
  logic sda_s1_ff, sda_s2_ff, sda_s3_ff;
  logic scl_rise, scl_fall, start_det, stop_det;

  // Link state
  pfs_bus_e bst_ff, nxt_bst;
  logic [2:0] bit_ff, nxt_bit;
  logic [7:0] shift_ff, nxt_shift;
  logic addr_ph_ff, nxt_addr_ph;
  logic rd_ff, nxt_rd;
  logic ara_ff, nxt_ara;
  logic [7:0] cmd_ff, nxt_cmd;
  logic [1:0] nb_ff, nxt_nb;
  logic txn_ff, nxt_txn;
  logic [7:0] crc_ff, nxt_crc;
  logic oe_ff, nxt_oe;
  logic frame_ff, nxt_frame;
  logic exec, ara_done;
  logic [7:0] rx_byte, tx_byte;
  logic me_hit, ara_hit;

  // Supervisor state
  logic [CFG_W-1:0] cfg_ff, nxt_cfg;
  logic loaded_ff, nxt_loaded;
  logic [CFG_W-1:0] img_ff, nxt_img;
  logic store_ff, nxt_store;
  logic [FLT_W-1:0] sticky_ff, nxt_sticky;
  logic alert_ff, nxt_alert;
  logic [15:0] rdata_ff, nxt_rdata;
  logic alert_drive, clr_all, ctrl_wr;

  function automatic logic [7:0] crc_step(input logic [7:0] c, input logic b);
    crc_step = {c[6:0], 1'b0} ^ ((c[7] ^ b) ? CRC_POLY : 8'h00);
  endfunction

  assign scl_rise = scl_s2_ff & ~scl_s3_ff;
  assign scl_fall = ~scl_s2_ff & scl_s3_ff;
  assign start_det = scl_s2_ff & scl_s3_ff & sda_s3_ff & ~sda_s2_ff;
  assign stop_det = scl_s2_ff & scl_s3_ff & ~sda_s3_ff & sda_s2_ff;
  assign alert_drive = alert_ff & ~cfg_ff[CTRL_MASK];

  always_comb begin
    nxt_bst = bst_ff;
    nxt_bit = bit_ff;
    nxt_shift = shift_ff;
    nxt_addr_ph = addr_ph_ff;
    nxt_rd = rd_ff;
    nxt_ara = ara_ff;
    nxt_cmd = cmd_ff;
    nxt_nb = nb_ff;
    nxt_txn = txn_ff;
    nxt_crc = crc_ff;
    nxt_oe = oe_ff;
    nxt_frame = frame_ff;
    exec = 1'b0;
    ara_done = 1'b0;
    rx_byte = {shift_ff[6:0], sda_s2_ff};
    me_hit = (rx_byte[7:1] == my_addr);
    // answer alert response only while alerting
    ara_hit = (rx_byte[7:1] == ADDR_ARA) & rx_byte[0] & alert_drive;
    tx_byte = IDLE_BYTE;
    if (txn_ff) begin
      tx_byte = crc_ff;
    end else if (ara_ff) begin
      tx_byte = {my_addr, 1'b0};
    end else if (cmd_ff == CMD_STATUS_BYTE) begin
      tx_byte = {alert_drive, sticky_ff};
    end
    if (start_det) begin
      nxt_bst = B_RX;
      nxt_bit = 3'h0;
      nxt_addr_ph = 1'b1;
      nxt_oe = 1'b0;
      nxt_txn = 1'b0;
      // Repeated start keeps the running checksum
      if (!frame_ff) begin
        nxt_crc = 8'h00;
        nxt_nb = 2'h0;
      end
    end else if (stop_det) begin
      nxt_bst = B_IDLE;
      nxt_oe = 1'b0;
      nxt_frame = 1'b0;
      exec = frame_ff & ~rd_ff & ((nb_ff == NB_SEND) |
        ((nb_ff == NB_SEND_PEC) & (crc_ff == 8'h00)));
    end else begin
      case (bst_ff)
        B_RX: begin
          if (scl_rise) begin
            nxt_shift = rx_byte;
            nxt_crc = crc_step(crc_ff, sda_s2_ff);
            nxt_bit = bit_ff + 3'h1;
            if (bit_ff == 3'h7) begin
              nxt_bst = B_RXACK;
              nxt_addr_ph = 1'b0;
              if (addr_ph_ff) begin
                nxt_rd = rx_byte[0];
                nxt_ara = ara_hit;
                nxt_frame = me_hit | ara_hit;
                if (!(me_hit || ara_hit)) begin
                  nxt_bst = B_IDLE;
                end
              end else begin
                if (nb_ff == 2'h0) begin
                  nxt_cmd = rx_byte;
                end
                if (nb_ff != 2'h3) begin
                  nxt_nb = nb_ff + 2'h1;
                end
              end
            end
          end
        end
        B_RXACK: begin
          if (scl_fall) begin
            nxt_oe = 1'b1;
            nxt_bst = B_ACKHOLD;
          end
        end
        B_ACKHOLD: begin
          if (scl_fall) begin
            if (rd_ff) begin
              nxt_shift = tx_byte;
              nxt_oe = ~tx_byte[7];
              nxt_bst = B_TX;
            end else begin
              nxt_oe = 1'b0;
              nxt_bst = B_RX;
            end
          end
        end
        B_TX: begin
          if (scl_rise) begin
            nxt_crc = crc_step(crc_ff, sda_s2_ff);
            nxt_bit = bit_ff + 3'h1;
            if (bit_ff == 3'h7) begin
              nxt_bst = B_TXACK;
            end
          end else if (scl_fall) begin
            nxt_shift = {shift_ff[6:0], 1'b0};
            nxt_oe = ~shift_ff[6];
          end
        end
        B_TXACK: begin
          if (scl_fall) begin
            nxt_oe = 1'b0;
          end else if (scl_rise) begin
            ara_done = ara_ff & ~txn_ff;
            nxt_txn = 1'b1;
            // host ack asks for the checksum byte
            nxt_bst = sda_s2_ff ? B_IDLE : B_ACKHOLD;
          end
        end
        B_IDLE: nxt_bst = B_IDLE;
        default: nxt_bst = B_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      scl_s1_ff <= 1'b1;
      scl_s2_ff <= 1'b1;
      scl_s3_ff <= 1'b1;
      sda_s1_ff <= 1'b1;
      sda_s2_ff <= 1'b1;
      sda_s3_ff <= 1'b1;
      bst_ff <= B_IDLE;
      bit_ff <= 3'h0;
      shift_ff <= 8'h00;
      addr_ph_ff <= 1'b0;
      rd_ff <= 1'b0;
      ara_ff <= 1'b0;
      cmd_ff <= 8'h00;
      nb_ff <= 2'h0;
      txn_ff <= 1'b0;
      crc_ff <= 8'h00;
      oe_ff <= 1'b0;
      frame_ff <= 1'b0;
    end else begin
      scl_s1_ff <= scl_in;
      scl_s2_ff <= scl_s1_ff;
      scl_s3_ff <= scl_s2_ff;
      sda_s1_ff <= sda_in;
      sda_s2_ff <= sda_s1_ff;
      sda_s3_ff <= sda_s2_ff;
      bst_ff <= nxt_bst;
      bit_ff <= nxt_bit;
      shift_ff <= nxt_shift;
      addr_ph_ff <= nxt_addr_ph;
      rd_ff <= nxt_rd;
      ara_ff <= nxt_ara;
      cmd_ff <= nxt_cmd;
      nb_ff <= nxt_nb;
      txn_ff <= nxt_txn;
      crc_ff <= nxt_crc;
      oe_ff <= nxt_oe;
      frame_ff <= nxt_frame;
    end
  end

  always_comb begin
    ctrl_wr = reg_wr_in & (reg_addr_in == REG_CTRL);
    clr_all = (exec & (cmd_ff == CMD_CLEAR_FAULTS)) | (ctrl_wr & reg_wdata_in[CTRL_CLR]);
    nxt_loaded = 1'b1;
    nxt_cfg = cfg_ff;
    // defaults come from nvm_default_in, once after reset
    if (!loaded_ff) begin
      nxt_cfg = nvm_default_in;
    end else if (ctrl_wr) begin
      nxt_cfg = reg_wdata_in[CFG_W-1:0];
    end
    nxt_store = exec & (cmd_ff == CMD_STORE_ALL);
    nxt_img = nxt_store ? cfg_ff : img_ff;
    nxt_sticky = (sticky_ff & ~{FLT_W{clr_all}}) | flt.event_p;
    nxt_alert = (alert_ff & ~(clr_all | (ara_done & ~cfg_ff[CTRL_ARA_OFF]))) |
      (|flt.event_p);
    nxt_rdata = 16'h0000;
    if (reg_rd_in) begin
      case (reg_addr_in)
        REG_CTRL: nxt_rdata = {13'h0000, cfg_ff};
        REG_STATUS: nxt_rdata = {addr_fb, my_addr, alert_drive, sticky_ff};
        REG_NVM: nxt_rdata = {13'h0000, img_ff};
        default: nxt_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      cfg_ff <= CFG_RST;
      loaded_ff <= 1'b0;
      img_ff <= CFG_RST;
      store_ff <= 1'b0;
      sticky_ff <= '0;
      alert_ff <= 1'b0;
      rdata_ff <= 16'h0000;
    end else begin
      cfg_ff <= nxt_cfg;
      loaded_ff <= nxt_loaded;
      img_ff <= nxt_img;
      store_ff <= nxt_store;
      sticky_ff <= nxt_sticky;
      alert_ff <= nxt_alert;
      rdata_ff <= nxt_rdata;
    end
  end

  assign flt.continuous = cfg_ff[CTRL_CONT];
  assign reg_rdata_out = rdata_ff;
  // data and alert lines only; clock line never driven
  assign sda_out = 1'b0;
  assign sda_oe_out = oe_ff;
  assign smbalert_out = 1'b0;
  assign smbalert_oe_out = alert_drive;
  assign nvm_image_out = img_ff;
  assign nvm_store_out = store_ff;
endmodule

// File: verilog/pfs_pkg.sv
package pfs_pkg;
  localparam int FLT_W = 7;
  localparam int F_VIN_UV = 0;
  localparam int F_UV = 1;
  localparam int F_OV = 2;
  localparam int F_HIGH_SIDE_OVERCURRENT = 3;
  localparam int F_LOW_SIDE_OVERCURRENT = 4;
  localparam int F_OT = 5;
  localparam int F_TSD = 6;
  localparam logic [6:0] ADDR_FALLBACK = 7'h7F;
  localparam logic [6:0] ADDR_ARA = 7'h0C;
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_STORE_ALL = 8'h15;
  localparam logic [7:0] CMD_STATUS_BYTE = 8'h78;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] IDLE_BYTE = 8'hFF;
  localparam logic [1:0] NB_SEND = 2'h1;
  localparam logic [1:0] NB_SEND_PEC = 2'h2;
  localparam logic [2:0] OC_LIMIT = 3'h7;
  localparam int HICCUP_SS_PERIODS = 7;
  localparam int CLK_MHZ = 200;
  localparam int SS_TIME_US = 1000;
  localparam int SS_CYCLES = SS_TIME_US * CLK_MHZ;
  localparam int ADDR_DIGITS = 8;
  localparam logic [7:0] ADDR_BAND_EDGE [0:8] = '{8'h08, 8'h14, 8'h1E, 8'h2C, 8'h40,
    8'h60, 8'h90, 8'hD0, 8'hF8};
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_NVM = 4'h8;
  localparam int CFG_W = 3;
  localparam int CTRL_CONT = 0;
  localparam int CTRL_ARA_OFF = 1;
  localparam int CTRL_MASK = 2;
  localparam int CTRL_CLR = 3;
  localparam logic [CFG_W-1:0] CFG_RST = 3'h0;
endpackage

// File: verilog/pfs_fault_if.sv
`timescale 1ns/100ps
interface pfs_fault_if import pfs_pkg::*; ();
  logic continuous;
  logic [FLT_W-1:0] active;
  logic [FLT_W-1:0] event_p;
  modport ctrl(input continuous, output active, output event_p);
  modport sup(output continuous, input active, input event_p);
endinterface

// File: verilog/pfs_addr_sel.sv
`timescale 1ns/100ps
module pfs_addr_sel import pfs_pkg::*; (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // Digitised select pin codes
  input wire logic [7:0] addr_select_low_in,
  input wire logic [7:0] addr_select_high_in,
  // Result
  output logic [6:0] addr_out,
  output logic fallback_out
);
  logic [3:0] lo;
  logic [3:0] hi;
  logic [6:0] nxt_addr;
  logic nxt_fb;

  function automatic logic [3:0] band(input logic [7:0] code);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 0; i < ADDR_DIGITS; i++) begin
      if (code >= ADDR_BAND_EDGE[i] && code < ADDR_BAND_EDGE[i+1]) begin
        r = {1'b1, 3'(i)};
      end
    end
    return r;
  endfunction

  always_comb begin
    lo = band(addr_select_low_in);
    hi = band(addr_select_high_in);
    nxt_fb = ~(lo[3] & hi[3]);
    nxt_addr = {1'b0, hi[2:0], lo[2:0]};
    if (nxt_fb) begin
      nxt_addr = ADDR_FALLBACK;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      addr_out <= ADDR_FALLBACK;
      fallback_out <= 1'b1;
    end else begin
      addr_out <= nxt_addr;
      fallback_out <= nxt_fb;
    end
  end
endmodule

// File: verilog/pfs_fault_ctrl.sv
`timescale 1ns/100ps
module pfs_fault_ctrl import pfs_pkg::*; #(
  parameter int HIC_CYC = SS_CYCLES * HICCUP_SS_PERIODS
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // Supervisor side
  pfs_fault_if.ctrl flt,
  // Raw sense levels, asynchronous
  input wire logic [10:0] sense_in,
  // Power stage
  output logic high_side_enable_out,
  output logic low_side_enable_out,
  output logic low_gate_drive_force_out,
  output logic soft_start_req_out
);
  typedef enum logic [2:0] {ST_RUN, ST_OV, ST_LATCH, ST_HICCUP, ST_HOT, ST_VIN} pfs_flt_e;
  pfs_flt_e st_ff, nxt_st;
  logic [10:0] s1_ff, s2_ff;
  logic cend_prev_ff;
  logic [2:0] oc_cnt_ff, nxt_oc_cnt;
  logic oc_seen_ff, nxt_oc_seen;
  logic [23:0] hic_ff, nxt_hic;
  logic ss_req_ff, nxt_ss_req;
  logic [FLT_W-1:0] evt_ff, nxt_evt;
  logic vin_uv, uv, ov, pg, high_side_overcurrent, low_side_overcurrent, ot, thermal_shutdown, tmp_ok, ss_done, cend, oc_trip, oc_over, hot;

  always_comb begin
    {cend, ss_done, tmp_ok, thermal_shutdown, ot, pg, low_side_overcurrent, high_side_overcurrent, ov, uv, vin_uv} = s2_ff;
    oc_trip = high_side_overcurrent | low_side_overcurrent;
    hot = thermal_shutdown | ot;
    nxt_st = st_ff;
    nxt_hic = hic_ff;
    nxt_ss_req = 1'b0;
    nxt_evt = '0;
    nxt_oc_cnt = oc_cnt_ff;
    nxt_oc_seen = (oc_seen_ff | oc_trip) & ~(cend & ~cend_prev_ff);
    if (cend && !cend_prev_ff) begin
      nxt_oc_cnt = (oc_seen_ff | oc_trip) ? oc_cnt_ff + 3'h1 : 3'h0;
    end
    oc_over = (nxt_oc_cnt == OC_LIMIT);
    if (st_ff != ST_RUN) begin
      nxt_oc_cnt = 3'h0;
    end
    case (st_ff)
      ST_RUN: begin
        if (hot) begin
          nxt_st = ST_HOT;
          nxt_evt[F_TSD] = thermal_shutdown;
          nxt_evt[F_OT] = ot;
        end else if (vin_uv) begin
          nxt_st = ST_VIN;
          nxt_evt[F_VIN_UV] = 1'b1;
        end else if (ov) begin
          nxt_st = ST_OV;
          nxt_evt[F_OV] = 1'b1;
        end else if ((uv && ss_done) || oc_over) begin
          nxt_evt[F_UV] = uv & ss_done;
          nxt_evt[F_HIGH_SIDE_OVERCURRENT] = oc_over & high_side_overcurrent;
          nxt_evt[F_LOW_SIDE_OVERCURRENT] = oc_over & ~high_side_overcurrent;
          nxt_st = flt.continuous ? ST_HICCUP : ST_LATCH;
          nxt_hic = '0;
        end
      end
      ST_OV: begin
        if (hot) begin
          nxt_st = ST_HOT;
        end else if (uv) begin
          nxt_evt[F_UV] = 1'b1;
          nxt_st = flt.continuous ? ST_HICCUP : ST_LATCH;
          nxt_hic = '0;
        end else if (pg && !ov) begin
          nxt_st = ST_RUN;
        end
      end
      ST_HOT: begin
        if (tmp_ok && !hot) begin
          nxt_st = ST_HICCUP;
          nxt_hic = '0;
        end
      end
      ST_HICCUP: begin
        nxt_hic = hic_ff + 24'h1;
        if (hot) begin
          nxt_st = ST_HOT;
        end else if (hic_ff == 24'(HIC_CYC - 1)) begin
          nxt_st = ST_RUN;
          nxt_ss_req = 1'b1;
        end
      end
      ST_VIN: begin
        if (!vin_uv) begin
          nxt_st = ST_RUN;
          nxt_ss_req = 1'b1;
        end
      end
      ST_LATCH: nxt_st = ST_LATCH;
      default: nxt_st = ST_LATCH;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      s1_ff <= '0;
      s2_ff <= '0;
      cend_prev_ff <= 1'b0;
      st_ff <= ST_RUN;
      oc_cnt_ff <= 3'h0;
      oc_seen_ff <= 1'b0;
      hic_ff <= '0;
      ss_req_ff <= 1'b0;
      evt_ff <= '0;
    end else begin
      s1_ff <= sense_in;
      s2_ff <= s1_ff;
      cend_prev_ff <= cend;
      st_ff <= nxt_st;
      oc_cnt_ff <= nxt_oc_cnt;
      oc_seen_ff <= nxt_oc_seen;
      hic_ff <= nxt_hic;
      ss_req_ff <= nxt_ss_req;
      evt_ff <= nxt_evt;
    end
  end

  assign high_side_enable_out = (st_ff == ST_RUN) & ~high_side_overcurrent;
  assign low_side_enable_out = (st_ff == ST_RUN) | (st_ff == ST_OV);
  assign low_gate_drive_force_out = (st_ff == ST_OV);
  assign soft_start_req_out = ss_req_ff;
  assign flt.event_p = evt_ff;
  assign flt.active = {st_ff == ST_HOT, st_ff == ST_HOT, 2'b00, st_ff == ST_OV,
    st_ff == ST_LATCH, st_ff == ST_VIN};
endmodule

// File: verification/pfs_top_sva.sv
`timescale 1ns/100ps
module pfs_top_sva import pfs_pkg::*; #(
  parameter int SS_CYC = 20
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // Watched pins
  input wire logic sda_out,
  input wire logic smbalert_out,
  input wire logic output_overvoltage_in,
  input wire logic high_side_overcurrent_in,
  input wire logic thermal_shutdown_in,
  input wire logic high_side_enable_out,
  input wire logic low_side_enable_out,
  input wire logic low_gate_drive_force_out,
  input wire logic soft_start_req_out,
  input wire logic [CFG_W-1:0] nvm_image_out,
  input wire logic nvm_store_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  a_od_low_only: assert property (!sda_out && !smbalert_out)
    else $error("open-drain pin driven high");
  a_force_stops_high: assert property (low_gate_drive_force_out |-> !high_side_enable_out && low_side_enable_out)
    else $error("discharge without low side only");
  a_force_from_ov: assert property ($rose(low_gate_drive_force_out) |->
    $past(output_overvoltage_in, 2) || $past(output_overvoltage_in, 3) || $past(output_overvoltage_in, 4))
    else $error("discharge without overvoltage");
  a_high_trip_cut: assert property ($past(high_side_overcurrent_in, 2) |-> !high_side_enable_out)
    else $error("high side on during trip");
  a_thermal_off: assert property ($past(thermal_shutdown_in, 3) |-> !high_side_enable_out && !low_side_enable_out)
    else $error("switch on while hot");
  a_ss_req_pulse: assert property (soft_start_req_out |=> !soft_start_req_out)
    else $error("restart request too long");
  a_ss_not_in_ov: assert property (soft_start_req_out |-> !low_gate_drive_force_out)
    else $error("restart during discharge");
  a_store_pulse: assert property (nvm_store_out |=> !nvm_store_out)
    else $error("store pulse too long");
  a_image_commit: assert property ($changed(nvm_image_out) |-> nvm_store_out || $past(nvm_store_out))
    else $error("image changed without store");
  c_store: cover property (nvm_store_out);
  c_discharge: cover property (low_gate_drive_force_out);
  c_restart: cover property (soft_start_req_out);
endmodule

// File: verification/pfs_host.sv
`timescale 1ns/100ps
module pfs_host (
  // Clock
  input wire logic clk_in,
  // Wire levels
  input wire logic sda_oe_in,
  output logic scl_out,
  output logic sda_out
);
  logic pull = 1'b0;
  initial scl_out = 1'b1;
  // Pull-up resistor: released line reads high
  assign sda_out = !(pull || sda_oe_in);
  task automatic q;
    repeat (4) @(posedge clk_in);
  endtask
  task automatic bit_io(input logic drv, output logic smp);
    q;
    pull <= drv;
    q;
    scl_out <= 1'b1;
    q;
    smp = sda_out;
    q;
    scl_out <= 1'b0;
  endtask
  task automatic start_bit;
    pull <= 1'b1;
    q;
    scl_out <= 1'b0;
  endtask
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic x;
    for (int i = 7; i >= 0; i--) bit_io(!b[i], x);
    bit_io(1'b0, ack);
  endtask
  task automatic get_byte(input logic nack, output logic [7:0] b);
    logic x;
    for (int i = 7; i >= 0; i--) bit_io(1'b0, b[i]);
    // Not acknowledging means releasing the line, so it reads high
    bit_io(!nack, x);
  endtask
  task automatic stop_bit;
    q;
    pull <= 1'b1;
    q;
    scl_out <= 1'b1;
    q;
    pull <= 1'b0;
    repeat (8) @(posedge clk_in);
  endtask
endmodule

// File: verification/pfs_top_tb.sv
`timescale 1ns/100ps
module pfs_top_tb;
  import pfs_pkg::*;
  localparam int SS_CYC = 20;
  localparam int HIC = SS_CYC * HICCUP_SS_PERIODS;
  logic clk_in, scl_w, sda_w, sda_oe, al_oe, hs_en, ls_en, force_ls, ss_req;
  logic rst_n = 1'b0, wr_s = 1'b0, rd_s = 1'b0, ovolt = 1'b0, uvolt = 1'b0, hot = 1'b0;
  logic hs_trip = 1'b0, ls_trip = 1'b0, win_ok = 1'b1, cool = 1'b1, cyc = 1'b0, ss_done = 1'b1;
  logic [3:0] ra = 4'h0;
  logic [15:0] wd = 16'h0;
  logic [15:0] rdata;
  logic [7:0] sel_lo = 8'h08, sel_hi = 8'h08;
  logic [CFG_W-1:0] nvm_def = '0, image;
  int mismatches = 0, check_count = 0;
  pfs_top #(.SS_CYC(SS_CYC)) pfs_top_inst (
    .clk_in(clk_in), .reset_n_in(rst_n), .reg_addr_in(ra), .reg_wdata_in(wd),
    .reg_wr_in(wr_s), .reg_rd_in(rd_s), .reg_rdata_out(rdata), .scl_in(scl_w), .sda_in(sda_w),
    .sda_out(), .sda_oe_out(sda_oe), .smbalert_out(), .smbalert_oe_out(al_oe),
    .addr_select_low_in(sel_lo), .addr_select_high_in(sel_hi), .input_undervoltage_in(1'b0),
    .output_undervoltage_in(uvolt), .output_overvoltage_in(ovolt), .power_good_window_in(win_ok),
    .high_side_overcurrent_in(hs_trip), .low_side_overcurrent_in(ls_trip),
    .external_overtemp_in(hot), .thermal_shutdown_in(hot), .temp_reset_ok_in(cool),
    .cycle_end_in(cyc), .soft_start_done_in(ss_done), .high_side_enable_out(hs_en),
    .low_side_enable_out(ls_en), .low_gate_drive_force_out(force_ls),
    .soft_start_req_out(ss_req), .nvm_default_in(nvm_def), .nvm_image_out(image),
    .nvm_store_out());
  pfs_host pfs_host_inst (.clk_in(clk_in), .sda_oe_in(sda_oe), .scl_out(scl_w), .sda_out(sda_w));
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    ra <= a;
    wd <= d;
    wr_s <= 1'b1;
    @(posedge clk_in);
    wr_s <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    ra <= a;
    rd_s <= 1'b1;
    @(posedge clk_in);
    rd_s <= 1'b0;
    #1 d = rdata;
    @(posedge clk_in);
  endtask
  task automatic wait_ss(input int lim, output int n);
    n = 0;
    do begin
      @(negedge clk_in);
      n++;
    end while (ss_req !== 1'b1 && n <= lim);
    if (n > lim) begin
      mismatches++;
      $display("ERROR t=%0t wait %h limit %h", $time, n, lim);
      wrap_up();
    end else begin
      @(posedge clk_in);
    end
  endtask
  function automatic logic [7:0] crc8(input logic [15:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? CRC_POLY : 8'h00);
    return c;
  endfunction
  function automatic logic [7:0] code_of(input int d);
    return ADDR_BAND_EDGE[d] + 8'($urandom_range(0, int'(ADDR_BAND_EDGE[d+1] - ADDR_BAND_EDGE[d]) - 1));
  endfunction
  task automatic set_addr(input int lo, input int hi);
    sel_lo <= code_of(lo);
    sel_hi <= code_of(hi);
    repeat (4) @(posedge clk_in);
  endtask
  task automatic send_cmd(input logic [6:0] a, input logic [7:0] c, output logic ack);
    logic x;
    pfs_host_inst.start_bit();
    pfs_host_inst.put_byte({a, 1'b0}, ack);
    pfs_host_inst.put_byte(c, x);
    pfs_host_inst.stop_bit();
  endtask
  // Mode 0 clean, 1 random side, 2 low side only
  task automatic oc_cycles(input int n, input int mode);
    int r;
    repeat (n) begin
      r = $urandom_range(0, 1);
      hs_trip <= mode == 1 && r == 1;
      ls_trip <= mode == 2 || (mode == 1 && r == 0);
      repeat (3) @(posedge clk_in);
      hs_trip <= 1'b0;
      ls_trip <= 1'b0;
      repeat (2) @(posedge clk_in);
      cyc <= 1'b1;
      repeat (4) @(posedge clk_in);
      cyc <= 1'b0;
    end
    @(posedge clk_in);
  endtask
  initial begin
    logic [15:0] v;
    logic [7:0] b;
    logic [2:0] cf;
    logic a;
    int n, lo, hi;
    void'($urandom(32'hB5086CC4));
    nvm_def <= CFG_W'($urandom);
    repeat (8) @(posedge clk_in);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_in);
    rd(REG_CTRL, v);
    chk(v, 16'(nvm_def));
    for (int i = 0; i < 6; i++) begin
      lo = $urandom_range(0, 7);
      hi = $urandom_range(0, 7);
      set_addr(lo, hi);
      rd(REG_STATUS, v);
      chk({8'h0, v[15:8]}, 16'(hi * 8 + lo));
    end
    sel_lo <= 8'h07;
    repeat (4) @(posedge clk_in);
    rd(REG_STATUS, v);
    chk({8'h0, v[15:8]}, 16'h00FF);
    $display("address test done");
    set_addr(lo, hi);
    cf = 3'($urandom);
    wr(REG_CTRL, {13'h0, cf});
    rd(REG_NVM, v);
    chk(v, 16'h0);
    send_cmd(7'(hi * 8 + lo), CMD_STORE_ALL, a);
    rd(REG_NVM, v);
    chk({v[14:0], a}, {12'h0, cf, 1'b0});
    wr(REG_CTRL, {13'h0, ~cf});
    // First pass carries a wrong checksum and must not commit
    for (int k = 0; k < 2; k++) begin
      pfs_host_inst.start_bit();
      pfs_host_inst.put_byte({7'(hi * 8 + lo), 1'b0}, a);
      pfs_host_inst.put_byte(CMD_STORE_ALL, a);
      pfs_host_inst.put_byte(crc8({7'(hi * 8 + lo), 1'b0, CMD_STORE_ALL}) ^ 8'(k == 0), a);
      pfs_host_inst.stop_bit();
      rd(REG_NVM, v);
      chk(v, {13'h0, k == 0 ? cf : ~cf});
    end
    send_cmd(7'(hi * 8 + lo) ^ 7'h40, CMD_STORE_ALL, a);
    chk(16'(a), 16'h1);
    set_addr(0, 0);
    send_cmd(7'h00, CMD_CLEAR_FAULTS, a);
    chk(16'(a), 16'h0);
    $display("link test done");
    ovolt <= 1'b1;
    win_ok <= 1'b0;
    repeat (8) @(posedge clk_in);
    chk({14'h0, force_ls, hs_en}, 16'h2);
    ovolt <= 1'b0;
    win_ok <= 1'b1;
    repeat (8) @(posedge clk_in);
    rd(REG_STATUS, v);
    chk({14'h0, force_ls, v[2]}, 16'h1);
    ss_done <= 1'b0;
    uvolt <= 1'b1;
    repeat (8) @(posedge clk_in);
    chk(16'(ls_en), 16'h1);
    uvolt <= 1'b0;
    ss_done <= 1'b1;
    $display("voltage test done");
    lo = $urandom_range(1, 7);
    set_addr(lo, 3);
    wr(REG_CTRL, 16'h0009);
    oc_cycles(6, 1);
    oc_cycles(1, 0);
    oc_cycles(6, 2);
    rd(REG_STATUS, v);
    chk(16'(v[4]), 16'h0);
    oc_cycles(1, 2);
    rd(REG_STATUS, v);
    chk({11'h0, al_oe, v[7], v[4], hs_en, ls_en}, 16'h1C);
    wait_ss(HIC + 20, n);
    chk(16'(n >= HIC - 30 && n <= HIC + 5), 16'h1);
    pfs_host_inst.start_bit();
    pfs_host_inst.put_byte({ADDR_ARA, 1'b1}, a);
    pfs_host_inst.get_byte(1'b1, b);
    pfs_host_inst.stop_bit();
    chk({7'h0, a, b}, {8'h0, 7'(24 + lo), 1'b0});
    chk(16'(al_oe), 16'h0);
    $display("overcurrent test done");
    hot <= 1'b1;
    cool <= 1'b0;
    repeat (8) @(posedge clk_in);
    chk({14'h0, hs_en, ls_en}, 16'h0);
    hot <= 1'b0;
    repeat (8) @(posedge clk_in);
    cool <= 1'b1;
    wait_ss(HIC + 20, n);
    chk(16'(n >= HIC - 20), 16'h1);
    $display("thermal test done");
    wrap_up();
  end
endmodule
bind pfs_top pfs_top_sva #(.SS_CYC(SS_CYC)) pfs_top_sva_inst (
  .clk_in(clk_in), .reset_n_in(reset_n_in), .sda_out(sda_out), .smbalert_out(smbalert_out),
  .output_overvoltage_in(output_overvoltage_in), .thermal_shutdown_in(thermal_shutdown_in),
  .high_side_overcurrent_in(high_side_overcurrent_in), .nvm_store_out(nvm_store_out),
  .high_side_enable_out(high_side_enable_out), .low_side_enable_out(low_side_enable_out),
  .low_gate_drive_force_out(low_gate_drive_force_out), .nvm_image_out(nvm_image_out),
  .soft_start_req_out(soft_start_req_out));
